// [rmcd_defs.vh]
`ifndef RMCD_DEFS_VH
`define RMCD_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Core clock rate in MHz
`define RMCD_CLK_MHZ 20
// Instruction cycle time in ns
`define RMCD_INSTR_NS 4000
// Core clocks per instruction cycle, rounded down
`define RMCD_CYC_CLKS ((`RMCD_INSTR_NS * `RMCD_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define RMCD_PC_W 10
`define RMCD_PTR_W 6
`define RMCD_DIG_W 4
`define RMCD_LATCH_W 8
`define RMCD_PIN_W 25
`define RMCD_PC_RST 10'h000
`define RMCD_PTR_RST 6'h00
`define RMCD_DIG_RST 4'h0
`define RMCD_LATCH_RST 8'h00
// Pin filter reset: idle levels, host strobe inputs high
`define RMCD_PIN_RST 25'h001E000
// Page that a page call lands in (arbitrary default)
`define RMCD_CALL_PAGE 4'h2

// ----------------------------------------------------------------
// Pin vector field positions
// ----------------------------------------------------------------
`define RMCD_PV_PD_HI 24
`define RMCD_PV_PD_LO 17
`define RMCD_PV_GI_HI 16
`define RMCD_PV_GI_LO 13
`define RMCD_PV_GP_HI 12
`define RMCD_PV_GP_LO 9
`define RMCD_PV_LP_HI 8
`define RMCD_PV_LP_LO 1
`define RMCD_PV_SI 0

// ----------------------------------------------------------------
// Enable register bits and host strobe input positions
// ----------------------------------------------------------------
`define RMCD_EN_CNT 0
`define RMCD_EN_LDRV 2
`define RMCD_EN_SO 3
`define RMCD_IN_RD 1
`define RMCD_IN_CS 2
`define RMCD_IN_WR 3

// ----------------------------------------------------------------
// Datapath commands
// ----------------------------------------------------------------
`define RMCD_OP_NOP 5'h00
`define RMCD_OP_ADD 5'h01
`define RMCD_OP_ADC 5'h02
`define RMCD_OP_LD 5'h03
`define RMCD_OP_ST 5'h04
`define RMCD_OP_XCH 5'h05
`define RMCD_OP_LDD 5'h06
`define RMCD_OP_XAD 5'h07
`define RMCD_OP_CAB 5'h08
`define RMCD_OP_CBR 5'h09
`define RMCD_OP_OBD 5'h0A
`define RMCD_OP_XAS 5'h0B
`define RMCD_OP_LEI 5'h0C
`define RMCD_OP_OMG 5'h0D
`define RMCD_OP_ING 5'h0E
`define RMCD_OP_CAMQ 5'h0F
`define RMCD_OP_CQMA 5'h10
`define RMCD_OP_INL 5'h11
`define RMCD_OP_TABLE_LOAD_OP 5'h12
`define RMCD_OP_JP 5'h13
`define RMCD_OP_PAGE_CALL_OP 5'h14
`define RMCD_OP_JID 5'h15
`define RMCD_OP_JMP 5'h16
`define RMCD_OP_JSR 5'h17
`define RMCD_OP_RET 5'h18
`define RMCD_OP_SC 5'h19
`define RMCD_OP_RC 5'h1A
`define RMCD_OP_ININ 5'h1B

`endif

// [rmcd_ram.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Digit store: synchronous write, registered read
// ----------------------------------------------------------------
module rmcd_ram #(
  parameter integer AW = 6,
  parameter integer DW = 4
)(
  // Clock
  input wire core_clk,
  // Access
  input wire [AW-1:0] addr,
  input wire wr_en,
  input wire [DW-1:0] wr_data,
  // Read data, one clock behind the address
  output wire [DW-1:0] rd_data
);

  // Storage array, contents undefined until written
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // Read data register
  reg [DW-1:0] rd_q;

  // Write port and registered read of the addressed digit
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_q <= mem[addr];
  end

  assign rd_data = rd_q;

endmodule

`default_nettype wire

// [rmcd_datapath.v]
// Function
// - 10-bit counter addresses 1,024 program words
// - Counter advances by one each instruction cycle
// - Three-deep last-in first-out return stack
// - Page ops use 16 pages of 64
// - 256-bit store as 4 x 16 digits
// - Pointer: 2 register bits, 4 digit bits
// - Direct ops address store from operand
// - Digit moves with accumulator, latch, port
// - Digit outputs loaded from digit select
// - Accumulator feeds pointer, latch, shifter
// - 4-bit adder, result to accumulator, carry
// - Carry steers serial clock, direct or sync
// - Inputs 1-3 optionally become host strobes
// - Port register drives bidir pins, ready option
// - 8-bit latch from store, accumulator, program
// - Latch reaches pins only while drivers on
// - Host write captures pins into latch
// - Positive logic everywhere but the active-low host strobes and reset
// - Selected host read drives latch onto pins
// - Strobes ignored while chip select high
// - Host write clears the ready output
// - Enable bit two switches drivers, not host
`include "rmcd_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rmcd_datapath #(
  parameter integer CYC_CLKS = `RMCD_CYC_CLKS,
  parameter [0:0] HOST_BUS = 1'b0,
  parameter [3:0] CALL_PAGE = `RMCD_CALL_PAGE
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Command from the instruction decoder
  input wire [4:0] op_code,
  input wire [9:0] op_operand,
  output wire cycle_start,
  // External program memory
  output wire [9:0] prog_addr,
  input wire [7:0] prog_data,
  // General inputs, host strobes under the host option
  input wire [3:0] general_inputs,
  // Digit outputs
  output wire [3:0] d_out,
  // Bidirectional port
  input wire [3:0] g_in,
  output wire [3:0] g_out,
  output wire [3:0] g_oe,
  // Parallel latch port
  input wire [7:0] l_in,
  output wire [7:0] l_out,
  output wire l_oe,
  // Serial pins
  input wire si_in,
  output wire shift_clock_out,
  output wire so_out,
  // State view
  output wire [3:0] acc_out,
  output wire carry_out,
  output wire [5:0] ptr_out
);

  // ----------------------------------------------------------------
  // Instruction cycle timing
  // ----------------------------------------------------------------
  localparam [6:0] PH_LAST = CYC_CLKS[6:0] - 7'h01;
  localparam [6:0] PH_HALF = CYC_CLKS[7:1];

  // Phase within the instruction cycle
  reg [6:0] ph_q;
  // Execute on the last phase of every cycle
  wire exec = (ph_q == PH_LAST);
  // Sync clock is high in the first half of a cycle
  wire sync = (ph_q < PH_HALF);

  // Phase counter, wraps once per instruction cycle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= 7'h00;
    end else if (exec) begin
      ph_q <= 7'h00;
    end else begin
      ph_q <= ph_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All asynchronous pins gathered in one vector
  wire [24:0] pin_raw = {prog_data, general_inputs, g_in, l_in, si_in};
  reg [24:0] s1_q;
  reg [24:0] s2_q;
  reg [24:0] s3_q;
  // Filtered pins: a bit moves once stages two and three agree
  reg [24:0] pin_q;
  integer k;

  // Three-stage capture, first stage read only by the second
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle levels, so the active-low strobes do not look
      // asserted while the stages refill after reset
      s1_q <= `RMCD_PIN_RST;
      s2_q <= `RMCD_PIN_RST;
      s3_q <= `RMCD_PIN_RST;
      pin_q <= `RMCD_PIN_RST;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (k = 0; k < `RMCD_PIN_W; k = k + 1) begin
        if (s2_q[k] == s3_q[k]) begin
          pin_q[k] <= s3_q[k];
        end
      end
    end
  end

  // Filtered fields
  wire [7:0] pd = pin_q[`RMCD_PV_PD_HI:`RMCD_PV_PD_LO];
  wire [3:0] gi = pin_q[`RMCD_PV_GI_HI:`RMCD_PV_GI_LO];
  wire [3:0] gp = pin_q[`RMCD_PV_GP_HI:`RMCD_PV_GP_LO];
  wire [7:0] lp = pin_q[`RMCD_PV_LP_HI:`RMCD_PV_LP_LO];
  wire si = pin_q[`RMCD_PV_SI];

  // ----------------------------------------------------------------
  // Host strobes
  // ----------------------------------------------------------------
  // option gating: strobes exist only with the host option
  wire host_sel = HOST_BUS & ~gi[`RMCD_IN_CS];
  wire host_rd = host_sel & ~gi[`RMCD_IN_RD];
  wire host_wr = host_sel & ~gi[`RMCD_IN_WR];

  // ----------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------
  reg [9:0] pc_q;     // Program counter
  reg [9:0] stk0_q;   // Return slot top
  reg [9:0] stk1_q;   // Return slot mid
  reg [9:0] stk2_q;   // Return slot bottom
  reg [5:0] ptr_q;    // Register select and digit select
  reg [3:0] a_q;      // Accumulator
  reg c_q;            // Carry flag
  reg [3:0] d_q;      // Digit output register
  reg [3:0] g_q;      // Bidirectional port register
  reg [7:0] q_q;      // Output latch
  reg [3:0] en_q;     // Enable register
  reg skl_q;          // Serial clock latch
  reg [3:0] sio_q;    // Shift register
  reg ready_q;        // Host ready flag
  reg [9:0] paddr_q;  // Program address pins
  reg cyc_q;          // Cycle start pulse
  reg [3:0] gout_q;   // Port pin drive
  reg [7:0] lout_q;   // Latch pin drive
  reg loe_q;          // Latch pin enable
  reg sk_q;           // Serial clock pin
  reg so_q;           // Serial data pin

  // ----------------------------------------------------------------
  // Digit store
  // ----------------------------------------------------------------
  // direct ops bypass the pointer
  wire direct = (op_code == `RMCD_OP_LDD) || (op_code == `RMCD_OP_XAD);
  // upper two bits pick the register, lower four the digit
  wire [5:0] ram_addr = direct ? op_operand[5:0] : ptr_q;
  wire [3:0] m;
  reg ram_we;
  reg [3:0] ram_wd;

  always @* begin
    ram_we = 1'b0;
    ram_wd = a_q;
    if (exec) begin
      case (op_code)
        `RMCD_OP_ST, `RMCD_OP_XCH, `RMCD_OP_XAD: begin
          ram_we = 1'b1;
        end
        `RMCD_OP_CQMA: begin
          ram_we = 1'b1;
          ram_wd = q_q[7:4];
        end
        `RMCD_OP_INL: begin
          ram_we = 1'b1;
          ram_wd = lp[7:4];
        end
        default: begin
          ram_we = 1'b0;
        end
      endcase
    end
  end

  // 4 registers of 16 digits, registered read
  rmcd_ram #(
    .AW(`RMCD_PTR_W),
    .DW(`RMCD_DIG_W)
  ) u_ram (
    .core_clk(core_clk),
    .addr(ram_addr),
    .wr_en(ram_we),
    .wr_data(ram_wd),
    .rd_data(m)
  );

  // ----------------------------------------------------------------
  // Adder and next sequential address
  // ----------------------------------------------------------------
  // carry-in only for the add-with-carry command
  wire cin = (op_code == `RMCD_OP_ADC) ? c_q : 1'b0;
  wire [4:0] sum = {1'b0, a_q} + {1'b0, m} + {4'h0, cin};
  wire [9:0] pc_inc = pc_q + 10'h001;
  // Table address from the current quarter, accumulator and digit
  wire [9:0] tbl_addr = {pc_q[9:8], a_q, m};
  wire tbl_op = (op_code == `RMCD_OP_TABLE_LOAD_OP) || (op_code == `RMCD_OP_JID);

  // ----------------------------------------------------------------
  // Execute: one command per instruction cycle
  // ----------------------------------------------------------------
  // all registers hold positive-logic bits
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= `RMCD_PC_RST;
      stk0_q <= `RMCD_PC_RST;
      stk1_q <= `RMCD_PC_RST;
      stk2_q <= `RMCD_PC_RST;
      ptr_q <= `RMCD_PTR_RST;
      a_q <= `RMCD_DIG_RST;
      c_q <= 1'b0;
      d_q <= `RMCD_DIG_RST;
      g_q <= `RMCD_DIG_RST;
      en_q <= `RMCD_DIG_RST;
      skl_q <= 1'b0;
      sio_q <= `RMCD_DIG_RST;
    end else if (exec) begin
      // default: advance to the next word
      pc_q <= pc_inc;
      // Shifter moves left each cycle unless in counter mode
      if (!en_q[`RMCD_EN_CNT]) begin
        sio_q <= {sio_q[2:0], si};
      end
      case (op_code)
        `RMCD_OP_ADD, `RMCD_OP_ADC: begin
          a_q <= sum[3:0];
          c_q <= sum[4];
        end
        `RMCD_OP_LD, `RMCD_OP_LDD: begin
          a_q <= m;
        end
        // exchange, store side handled by the write port
        `RMCD_OP_XCH, `RMCD_OP_XAD: begin
          a_q <= m;
        end
        `RMCD_OP_CAB: begin
          ptr_q[3:0] <= a_q;
        end
        `RMCD_OP_CBR: begin
          ptr_q[5:4] <= a_q[1:0];
        end
        // digit select onto the digit outputs
        `RMCD_OP_OBD: begin
          d_q <= ptr_q[3:0];
        end
        // swap with shifter, carry into clock latch
        `RMCD_OP_XAS: begin
          a_q <= sio_q;
          sio_q <= a_q;
          skl_q <= c_q;
        end
        `RMCD_OP_LEI: begin
          en_q <= op_operand[3:0];
        end
        // store digit to the port register
        `RMCD_OP_OMG: begin
          g_q <= m;
        end
        `RMCD_OP_ING: begin
          a_q <= gp;
        end
        // latch halves into accumulator and store
        `RMCD_OP_CQMA: begin
          a_q <= q_q[3:0];
        end
        // parallel port into accumulator and store
        `RMCD_OP_INL: begin
          a_q <= lp[3:0];
        end
        // jump within the current 64-word page
        `RMCD_OP_JP: begin
          pc_q <= {pc_q[9:6], op_operand[5:0]};
        end
        // page call pushes the return address
        `RMCD_OP_PAGE_CALL_OP: begin
          pc_q <= {CALL_PAGE, op_operand[5:0]};
          stk0_q <= pc_inc;
          stk1_q <= stk0_q;
          stk2_q <= stk1_q;
        end
        // indirect jump through a table word
        `RMCD_OP_JID: begin
          pc_q <= {pc_q[9:8], pd};
        end
        `RMCD_OP_JMP: begin
          pc_q <= op_operand;
        end
        `RMCD_OP_JSR: begin
          pc_q <= op_operand;
          stk0_q <= pc_inc;
          stk1_q <= stk0_q;
          stk2_q <= stk1_q;
        end
        // pop top slot into the counter
        `RMCD_OP_RET: begin
          pc_q <= stk0_q;
          stk0_q <= stk1_q;
          stk1_q <= stk2_q;
        end
        `RMCD_OP_SC: begin
          c_q <= 1'b1;
        end
        `RMCD_OP_RC: begin
          c_q <= 1'b0;
        end
        // general inputs read as plain bits
        `RMCD_OP_ININ: begin
          a_q <= gi;
        end
        default: begin
          a_q <= a_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output latch and ready flag
  // ----------------------------------------------------------------
  // Host capture wins over a program load in the same cycle,
  // since the host cannot be told to retry
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_q <= `RMCD_LATCH_RST;
    end else if (host_wr) begin
      // pins captured while the strobe is active
      q_q <= lp;
    end else if (exec && op_code == `RMCD_OP_CAMQ) begin
      q_q <= {a_q, m};
    end else if (exec && op_code == `RMCD_OP_TABLE_LOAD_OP) begin
      q_q <= pd;
    end
  end

  // host write clears ready; a program set in the same cycle wins
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_q <= 1'b0;
    end else if (exec && op_code == `RMCD_OP_OMG) begin
      ready_q <= m[0];
    end else if (host_wr) begin
      ready_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  // Program address: counter first, table address in second half
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      paddr_q <= `RMCD_PC_RST;
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= exec;
      if (ph_q == 7'h00) begin
        paddr_q <= pc_q;
      end else if (ph_q == PH_HALF && tbl_op) begin
        // table word within the current quarter
        paddr_q <= tbl_addr;
      end
    end
  end

  // Port, latch and serial pins
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gout_q <= `RMCD_DIG_RST;
      lout_q <= `RMCD_LATCH_RST;
      loe_q <= 1'b0;
      sk_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      // ready replaces port bit zero only with the option
      gout_q <= HOST_BUS ? {g_q[3:1], ready_q} : g_q;
      lout_q <= q_q;
      // host read or enable bit two drives pins
      loe_q <= HOST_BUS ? host_rd : en_q[`RMCD_EN_LDRV];
      // carry latch direct in counter mode, else gated sync
      sk_q <= en_q[`RMCD_EN_CNT] ? skl_q : (skl_q & sync);
      so_q <= en_q[`RMCD_EN_CNT] ? en_q[`RMCD_EN_SO] :
              (en_q[`RMCD_EN_SO] & sio_q[3]);
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign cycle_start = cyc_q;
  assign prog_addr = paddr_q;
  assign d_out = d_q;
  assign g_out = gout_q;
  // Port pins driven throughout; inputs read the pin level
  assign g_oe = 4'hF;
  assign l_out = lout_q;
  assign l_oe = loe_q;
  assign shift_clock_out = sk_q;
  assign so_out = so_q;
  assign acc_out = a_q;
  assign carry_out = c_q;
  assign ptr_out = ptr_q;

endmodule

`default_nettype wire

// [rmcd_prog_mem.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// External program store model
// ----------------------------------------------------------------
module rmcd_prog_mem #(
  parameter [0:0] SLOW = 1'b0 // Slow part: word settles one clock late
)(
  // Clock
  input wire logic core_clk,
  // Address in, word out
  input wire logic [9:0] prog_addr,
  output logic [7:0] prog_data
);
  // Address seen at the last edge, to spot a change
  logic [9:0] addr_q;
  // Stored word, a fixed pattern of all ten address bits
  logic [7:0] word;

  assign word = prog_addr[7:0] ^ {prog_addr[9:8], 6'h3C};

  // Track the address so a slow part can lag behind it
  always @(posedge core_clk) begin
    addr_q <= prog_addr;
  end

  // No stale word while settling: the inverse shows, not the old value
  assign prog_data = (SLOW && addr_q != prog_addr) ? ~word : word;
endmodule
`default_nettype wire

// [rmcd_datapath_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rmcd_defs.vh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module rmcd_datapath_chk #(
  parameter integer CYC_CLKS = 80,
  parameter [0:0] HOST_BUS = 1'b0
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command side
  input wire logic [4:0] op_code,
  input wire logic [9:0] op_operand,
  input wire logic cycle_start,
  input wire logic [9:0] prog_addr,
  // Pins
  input wire logic [3:0] general_inputs,
  input wire logic [3:0] d_out,
  input wire logic [3:0] g_in,
  input wire logic [3:0] g_out,
  input wire logic [7:0] l_in,
  input wire logic [7:0] l_out,
  input wire logic l_oe,
  // State view
  input wire logic [3:0] acc_out,
  input wire logic [5:0] ptr_out
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Clocks since the last cycle pulse
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  // First pulse seen, so the reset gap is not judged
  logic seen_q;

  // Next gap count
  always_comb begin
    gap_d = cycle_start ? 8'h00 : gap_q + 8'h01;
  end

  // Gap counter and first pulse flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_q | cycle_start;
    end
  end

  // Host strobes held long enough to pass the pin filter
  sequence s_host_wr;
    (HOST_BUS && !general_inputs[`RMCD_IN_CS]
      && !general_inputs[`RMCD_IN_WR]) [*8];
  endsequence
  sequence s_host_rd;
    (HOST_BUS && !general_inputs[`RMCD_IN_CS]
      && !general_inputs[`RMCD_IN_RD]) [*7];
  endsequence

  a_start_period: assert property (
    cycle_start && seen_q |-> gap_q == CYC_CLKS - 1)
    else $error("cycle pulse spacing wrong");
  a_pc_step: assert property (
    cycle_start && $past(op_code) == `RMCD_OP_NOP
    |=> prog_addr == $past(prog_addr, CYC_CLKS) + 10'h001)
    else $error("program address did not step by one");
  a_page_jump: assert property (
    cycle_start && $past(op_code) == `RMCD_OP_JP |=>
    (((prog_addr ^ $past(prog_addr, 3)) & 10'h3C0)
    | ((prog_addr ^ $past(op_operand, 2)) & 10'h03F)) == 10'h000)
    else $error("page jump left its page");
  a_call_target: assert property (
    cycle_start && $past(op_code) == `RMCD_OP_JSR
    |=> prog_addr == $past(op_operand, 2))
    else $error("call target wrong");
  a_digit_src: assert property (
    $changed(d_out) |-> d_out == ptr_out[3:0])
    else $error("digit outputs not from digit select");
  a_port_read: assert property (
    cycle_start && $past(op_code) == `RMCD_OP_ING
    |-> acc_out == $past(g_in, 2))
    else $error("port read wrong");
  a_ptr_low: assert property (
    cycle_start && $past(op_code) == `RMCD_OP_CAB
    |-> ptr_out[3:0] == $past(acc_out))
    else $error("digit select not loaded from accumulator");
  a_host_write: assert property (
    s_host_wr |=> !g_out[0] && l_out == $past(l_in, 4))
    else $error("host write not captured");
  a_read_drive: assert property (s_host_rd |-> l_oe)
    else $error("host read did not drive latch pins");
  a_cs_ignore: assert property (
    (HOST_BUS && general_inputs[`RMCD_IN_CS]) [*7] |-> !l_oe)
    else $error("latch pins driven while not selected");
endmodule
`default_nettype wire

// [rmcd_datapath_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rmcd_defs.vh"
// Compare one value with its expected figure
`define CHK(a, e) chk(64'(a), 64'(e))

module rmcd_datapath_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam integer CYC = 20; // Short cycle, room for the table fetch
  logic core_clk, rst_b, si_in;
  logic [4:0] op_code;
  logic [9:0] op_operand;
  logic [3:0] general_inputs, g_in;
  logic [7:0] l_in;
  wire cycle_start, l_oe, shift_clock_out, carry_out, so_out;
  wire [9:0] prog_addr;
  wire [7:0] prog_data, l_out;
  wire [3:0] d_out, g_out, g_oe, acc_out;
  wire [5:0] ptr_out;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  logic [9:0] pc_seen; // Address shown just after each launch
  // Rows: code, operand, port pins, accumulator, carry, pointer
  logic [35:0] rows [17];
  // Rows: code, operand, address this command must sit at
  logic [31:0] flow [17];

  rmcd_datapath #(.CYC_CLKS(CYC), .HOST_BUS(1'b1)) dut_u (
    .core_clk, .rst_b, .op_code, .op_operand, .cycle_start, .prog_addr,
    .prog_data, .general_inputs, .d_out, .g_in, .g_out, .g_oe, .l_in,
    .l_out, .l_oe, .si_in, .shift_clock_out, .so_out, .acc_out,
    .carry_out, .ptr_out
  );
  rmcd_prog_mem #(.SLOW(1'b1)) mem_u (.core_clk, .prog_addr, .prog_data);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t got %0h want %0h", $time, got, want);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatched %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Inputs always move the same 2 ns after a rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask

  // Launch one command, return once it has executed
  task automatic op(input logic [4:0] c, input logic [9:0] o);
    int i;
    op_code = c;
    op_operand = o;
    for (i = 0; i < 3 * CYC; i++) begin
      tick(1);
      if (i == 0) pc_seen = prog_addr;
      if (cycle_start === 1'b1) break;
    end
    // A missing pulse is a hang: stop here
    if (i == 3 * CYC) begin
      mismatches++;
      results();
    end
  endtask

  // Reset for two clocks, check the idle outputs, release
  task automatic rst_chk();
    rst_b = 1'b0;
    tick(2);
    `CHK({acc_out, carry_out, ptr_out}, 11'h000);
    `CHK({prog_addr, d_out, l_out, l_oe, g_oe}, 27'h000000F);
    rst_b = 1'b1;
    // no latch drive while the filter wakes up
    tick(2);
    `CHK(l_oe, 1'b0);
    op(`RMCD_OP_NOP, 10'h000);
    $display("Reset test done");
  endtask

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{36'h0E0055000, 36'h040055000, 36'h0E0033000, 36'h090033030,
      36'h0E00CC030, 36'h0800CC03C, 36'h0400CC03C, 36'h0E009903C,
      36'h01009513C, 36'h02009213C, 36'h1A009203C, 36'h06009503C,
      36'h073C9C03C, 36'h03009503C, 36'h19009513C, 36'h01009A03C,
      36'h1F009A03C};
    flow = '{32'h00000050, 32'h17100051, 32'h17200100, 32'h17300200,
      32'h173F0300, 32'h180003F0, 32'h18000301, 32'h18000201,
      32'h18000101, 32'h1302A101, 32'h1400512A, 32'h18000085,
      32'h163FF12B, 32'h000003FF, 32'h00000000, 32'h15000001,
      32'h12000099};
    op_code = `RMCD_OP_NOP;
    op_operand = 10'h000;
    general_inputs = 4'hF;
    g_in = 4'h0;
    l_in = 8'h00;
    si_in = 1'b0;
    rst_chk();
    // Moves, adder, direct access, unknown code
    for (n = 0; n < 17; n++) begin
      g_in = rows[n][19:16];
      op(rows[n][32:28], {2'b00, rows[n][27:20]});
      `CHK(acc_out, rows[n][15:12]);
      `CHK(carry_out, rows[n][8]);
      `CHK(ptr_out, rows[n][5:0]);
    end
    $display("Row table done");
    // Stack overflow, pages, wrap, table fetch
    op(`RMCD_OP_OBD, 10'h000);
    op(`RMCD_OP_JMP, 10'h050);
    `CHK(d_out, 4'hC);
    for (n = 0; n < 17; n++) begin
      op(flow[n][28:24], flow[n][21:12]);
      `CHK(pc_seen, flow[n][9:0]);
    end
    $display("Flow table done");
    // Latch moves; pin and store results read one command later
    op(`RMCD_OP_OMG, 10'h000);
    `CHK(l_out, 8'h99);
    op(`RMCD_OP_CAMQ, 10'h000);
    `CHK(g_out, 4'h5);
    op(`RMCD_OP_CQMA, 10'h000);
    `CHK({l_out, acc_out}, 12'hA55);
    op(`RMCD_OP_LD, 10'h000);
    `CHK(acc_out, 4'hA);
    op(`RMCD_OP_LEI, 10'h004);
    op(`RMCD_OP_NOP, 10'h000);
    `CHK(l_oe, 1'b0);
    // Write strobe while not selected
    l_in = 8'h11;
    general_inputs = 4'h6;
    tick(12);
    general_inputs = 4'hF;
    tick(6);
    `CHK({l_out, g_out[0]}, 9'h14B);
    // Selected write
    l_in = 8'h6B;
    general_inputs = 4'h2;
    tick(12);
    general_inputs = 4'hF;
    tick(6);
    `CHK({l_out, g_out[0]}, 9'h0D6);
    // Selected read, then read while not selected
    general_inputs = 4'h8;
    tick(8);
    `CHK(l_oe, 1'b1);
    general_inputs = 4'hC;
    tick(8);
    `CHK(l_oe, 1'b0);
    general_inputs = 4'hF;
    op(`RMCD_OP_INL, 10'h000);
    `CHK(acc_out, 4'hB);
    op(`RMCD_OP_LD, 10'h000);
    `CHK(acc_out, 4'h6);
    $display("Latch and host tests done");
    // Serial clock: steady level, then one burst per cycle
    op(`RMCD_OP_SC, 10'h000);
    op(`RMCD_OP_LEI, 10'h009);
    op(`RMCD_OP_XAS, 10'h000);
    op(`RMCD_OP_NOP, 10'h000);
    `CHK({shift_clock_out, so_out}, 2'b11);
    op(`RMCD_OP_LEI, 10'h000);
    op(`RMCD_OP_NOP, 10'h000);
    n = 0;
    repeat (CYC) begin
      tick(1);
      if (shift_clock_out === 1'b1) n++;
    end
    `CHK(n, CYC / 2);
    $display("Serial test done");
    rst_chk();
    results();
  end
endmodule

bind rmcd_datapath rmcd_datapath_chk #(
  .CYC_CLKS(CYC_CLKS), .HOST_BUS(HOST_BUS)
) chk_u (
  .core_clk, .rst_b, .op_code, .op_operand, .cycle_start, .prog_addr,
  .general_inputs, .d_out, .g_in, .g_out, .l_in, .l_out, .l_oe,
  .acc_out, .ptr_out
);
`default_nettype wire
